// ### dlt_ctrl.sv
// Loopback, test pattern, defect and craft port control for the DS3 unit
// Overview of operation
// [RULE_01] Network loss: indicator on, all ones toward customer.
// [RULE_02] Customer loss: indicator on, keep-alive choice toward network.
// [RULE_03] No C-bit and no M13 framing means unframed.
// [RULE_04] FEAC loop-up on C-bit signal starts network loopback.
// [RULE_05] FEAC loop-down ends network loopback.
// [RULE_06] Card failure or flash upgrade requests bypass.
// [RULE_07] Far end sends arming code for five seconds.
// [RULE_08] Identifiers taken only in twenty seconds after arming.
// [RULE_09] Loopback identifier loops signal back toward network.
// [RULE_10] Pattern identifiers send pattern both ways.
// [RULE_11] Release code ends loopback or pattern at once.
// [RULE_12] Inband pattern framed as network side at start.
// [RULE_13] User identifier sends last craft-set pattern.
// [RULE_14] Button or craft starts or ends a loopback.
// [RULE_15] Test released after 20, 60, 120 min or 24 h.
// [RULE_16] FEAC loop-up in a test restarts timeout.
// [RULE_17] Craft may disable timeout.
// [RULE_18] Craft frame: eight data, no parity, one stop.
// [RULE_19] Craft rates 1.2 to 19.2 kbps.
// [RULE_20] SEF at three F-bit errors in sixteen; clears in frame.
// [RULE_21] FEBE counted on C-bit when bits not all ones.
// [RULE_22] Excessive zeros: more than two zeros in a row.
// [RULE_23] BPV counted unless part of zero substitution.
// [RULE_24] Pattern and loopback never at once.
// [RULE_25] No identifier in window drops armed state.
`timescale 1ns/1ps
module dlt_ctrl #(
  parameter int SEC_TICK = dlt_pkg::SEC_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire dlt_pkg::dlt_side_t network_side,
  input wire dlt_pkg::dlt_side_t customer_side,
  input wire logic feac_loop_up,
  input wire logic feac_loop_down,
  input wire logic arm_code_present,
  input wire logic release_code,
  input wire logic id_valid,
  input wire logic [15:0] id_code,
  input wire logic loopback_select_button,
  input wire logic card_fail,
  input wire logic fbit_valid,
  input wire logic fbit_error,
  input wire logic in_frame,
  input wire logic febe_valid,
  input wire logic [2:0] febe_bits,
  input wire logic line_bit_valid,
  input wire logic line_bit,
  input wire logic pulse_valid,
  input wire logic pulse_negative,
  input wire logic pulse_in_subst,
  input wire logic craft_rxd,
  output logic craft_txd,
  output dlt_pkg::dlt_led_t network_loss_indicator,
  output dlt_pkg::dlt_led_t customer_loss_indicator,
  output dlt_pkg::dlt_tx_t net_tx_sel,
  output dlt_pkg::dlt_tx_t customer_side_tx_sel,
  output dlt_pkg::dlt_pat_t pattern_sel,
  output dlt_pkg::dlt_frame_t pattern_framing,
  output logic [15:0] user_pattern,
  output logic bypass_request,
  output logic sef_defect,
  output logic exz_flag
);
  import dlt_pkg::*;

  if (SEC_TICK < 2) begin : g_bad_tick
    $error("SEC_TICK must be at least 2");
  end

  typedef enum {IB_IDLE, IB_ARMING, IB_ARMED} dlt_ib_t;

  dlt_ib_t ib_state;
  logic [31:0] tick_cnt;
  logic sec_tick;
  logic [4:0] ib_sec;
  logic [6:0] prov;
  dlt_loop_t loop_mode;
  logic pat_on;
  logic [16:0] tmo_sec;
  logic [16:0] tmo_limit;
  logic [15:0] baud_div;
  logic [15:0] febe_cnt;
  logic [15:0] bpv_cnt;
  logic [SEF_WINDOW-1:0] fhist;
  logic [1:0] zero_run;
  logic prev_neg;
  logic [7:0] rx_data;
  logic rx_valid;
  logic [9:0] tx_shift;
  logic [3:0] tx_bits;
  logic [15:0] tx_baud;
  logic [3:0] rx_bits;
  logic [15:0] rx_baud;
  logic rx_busy;
  logic [7:0] rx_shift;

  logic acc;
  logic wr;
  logic rd;
  logic addr_ok;
  logic id_take;
  logic active;
  logic timeout_evt;
  logic release_evt;
  logic [SEF_WINDOW-1:0] next_fhist;
  logic [4:0] err_cnt;

  assign acc = psel & penable & pready;
  assign wr = acc & pwrite & addr_ok;
  assign rd = acc & ~pwrite & addr_ok;
  assign id_take = (ib_state == IB_ARMED) & id_valid;
  assign active = pat_on | (loop_mode != LB_NONE);

  always_comb begin
    unique case (paddr)
      ADDR_PROV, ADDR_CMD, ADDR_STATUS, ADDR_USER_PAT, ADDR_UART_RX,
      ADDR_UART_TX, ADDR_FEBE_CNT, ADDR_BPV_CNT: addr_ok = 1'b1;
      ADDR_BAUD_DIV: addr_ok = ~pwrite |
        (pwdata[15:0] >= DIV_MIN && pwdata[15:0] <= DIV_MAX);
      default: addr_ok = 1'b0;
    endcase
  end

  // APB slave: no wait states, pready is already high in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel & ~penable & ~pready;
      pslverr <= psel & ~penable & ~pready & ~addr_ok;
      prdata <= 32'h0000_0000;
      if (psel && !penable && !pwrite) begin
        unique case (paddr)
          ADDR_PROV: prdata <= {25'h000_0000, prov};
          ADDR_STATUS: prdata <= {16'h0000, 2'(ib_state), rx_valid,
            (tx_bits != 4'h0), sef_defect, exz_flag, pat_on,
            3'(pattern_sel), 2'(loop_mode), network_side.los,
            customer_side.los, 2'(pattern_framing)};
          ADDR_USER_PAT: prdata <= {16'h0000, user_pattern};
          ADDR_BAUD_DIV: prdata <= {16'h0000, baud_div};
          ADDR_UART_RX: prdata <= {23'h00_0000, rx_valid, rx_data};
          ADDR_FEBE_CNT: prdata <= {16'h0000, febe_cnt};
          ADDR_BPV_CNT: prdata <= {16'h0000, bpv_cnt};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Provisioning, user pattern and baud divisor
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prov <= PROV_RESET;
      user_pattern <= USER_PAT_RESET;
      baud_div <= DIV_RESET;
    end else if (wr) begin
      if (paddr == ADDR_PROV) begin
        prov <= pwdata[6:0];
      end
      // [RULE_13] Craft-programmed pattern
      if (paddr == ADDR_USER_PAT) begin
        user_pattern <= pwdata[15:0];
      end
      // [RULE_19] Only rates within range accepted
      if (paddr == ADDR_BAUD_DIV) begin
        baud_div <= pwdata[15:0];
      end
    end
  end

  // One second time base; long timers count seconds to stay narrow
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt <= 32'h0000_0000;
      sec_tick <= 1'b0;
    end else begin
      sec_tick <= (tick_cnt == 32'(SEC_TICK - 2));
      if (tick_cnt == 32'(SEC_TICK - 1)) begin
        tick_cnt <= 32'h0000_0000;
      end else begin
        tick_cnt <= tick_cnt + 32'h0000_0001;
      end
    end
  end

  // Inband arming sequence
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ib_state <= IB_IDLE;
      ib_sec <= 5'h00;
    end else begin
      unique case (ib_state)
        IB_IDLE: begin
          ib_sec <= 5'h00;
          if (prov[PROV_INBAND] && arm_code_present) begin
            ib_state <= IB_ARMING;
          end
        end
        // [RULE_07] Arming code held for five seconds
        IB_ARMING: begin
          if (!arm_code_present || !prov[PROV_INBAND]) begin
            ib_state <= IB_IDLE;
          end else if (sec_tick) begin
            ib_sec <= ib_sec + 5'h01;
            if (ib_sec == 5'(ARM_TIME_S - 1)) begin
              ib_state <= IB_ARMED;
              ib_sec <= 5'h00;
            end
          end
        end
        // [RULE_08] Identifier window
        IB_ARMED: begin
          if (id_take || release_code) begin
            ib_state <= IB_IDLE;
          end else if (sec_tick) begin
            ib_sec <= ib_sec + 5'h01;
            // [RULE_25] Window expired, rearm required
            if (ib_sec == 5'(ID_WINDOW_S - 1)) begin
              ib_state <= IB_IDLE;
            end
          end
        end
      endcase
    end
  end

  always_comb begin
    unique case (dlt_tmo_t'(prov[PROV_TMO_LSB +: 3]))
      TMO_20: tmo_limit = TMO_20_S;
      TMO_60: tmo_limit = TMO_60_S;
      TMO_120: tmo_limit = TMO_120_S;
      TMO_24H: tmo_limit = TMO_24H_S;
      default: tmo_limit = 17'h0_0000;
    endcase
  end

  // [RULE_15] Timeout expiry
  // [RULE_17] Zero limit means timeout disabled
  assign timeout_evt = active & sec_tick & (tmo_limit != 17'h0_0000) &
    (tmo_sec == tmo_limit - 17'h0_0001);
  // [RULE_11] Release wins over every start
  assign release_evt = release_code | timeout_evt |
    (wr & (paddr == ADDR_CMD) & pwdata[CMD_RELEASE]);

  // Test state: loopback mode, pattern and timeout
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      loop_mode <= LB_NONE;
      pat_on <= 1'b0;
      pattern_sel <= PAT_PRBS23;
      pattern_framing <= FR_UNFR;
      tmo_sec <= 17'h0_0000;
    end else begin
      if (!active) begin
        tmo_sec <= 17'h0_0000;
      end else if (sec_tick) begin
        tmo_sec <= tmo_sec + 17'h0_0001;
      end
      if (release_evt) begin
        loop_mode <= LB_NONE;
        pat_on <= 1'b0;
      end else if (feac_loop_up && network_side.cbit_found) begin
        // [RULE_04] FEAC loop-up
        loop_mode <= LB_NET;
        pat_on <= 1'b0;
        // [RULE_16] Restart timeout
        tmo_sec <= 17'h0_0000;
      end else if (feac_loop_down) begin
        // [RULE_05] FEAC loop-down
        if (loop_mode == LB_NET) begin
          loop_mode <= LB_NONE;
        end
      end else if (id_take) begin
        tmo_sec <= 17'h0_0000;
        if (id_code == ID_LOOPBACK) begin
          // [RULE_09] Loopback toward network
          loop_mode <= LB_NET;
          pat_on <= 1'b0;
        end else if (id_code == ID_PRBS23 || id_code == ID_QRSS ||
                     id_code == ID_BLUE || id_code == ID_IDLE ||
                     id_code == ID_USER) begin
          // [RULE_24] Pattern replaces any loopback
          loop_mode <= LB_NONE;
          pat_on <= 1'b1;
          // [RULE_10] Pattern choice
          unique case (id_code)
            ID_PRBS23: pattern_sel <= PAT_PRBS23;
            ID_QRSS: pattern_sel <= PAT_QRSS;
            ID_BLUE: pattern_sel <= PAT_BLUE;
            ID_IDLE: pattern_sel <= PAT_IDLE;
            default: pattern_sel <= PAT_USER;
          endcase
          // [RULE_12] Frame as network side now
          if (network_side.cbit_found) begin
            pattern_framing <= FR_CBIT;
          end else if (network_side.m13_found) begin
            pattern_framing <= FR_M13;
          end else begin
            pattern_framing <= FR_UNFR;
          end
        end
      end else if (wr && paddr == ADDR_CMD) begin
        tmo_sec <= 17'h0_0000;
        // [RULE_14] Craft start of a loopback
        if (pwdata[CMD_LOOP_GO]) begin
          loop_mode <= dlt_loop_t'(pwdata[CMD_LOOP_LSB +: 2]);
          pat_on <= 1'b0;
        end else if (pwdata[CMD_PAT_GO]) begin
          // [RULE_24] Pattern clears loopback
          loop_mode <= LB_NONE;
          pat_on <= 1'b1;
          pattern_sel <= dlt_pat_t'(pwdata[CMD_PAT_LSB +: 3]);
        end
      end else if (loopback_select_button) begin
        // [RULE_14] Button toggles the loopback
        tmo_sec <= 17'h0_0000;
        pat_on <= 1'b0;
        loop_mode <= (loop_mode == LB_NONE) ? LB_NET : LB_NONE;
      end
    end
  end

  // Transmit selection and indicators
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      net_tx_sel <= TX_THRU;
      customer_side_tx_sel <= TX_THRU;
      network_loss_indicator <= '0;
      customer_loss_indicator <= '0;
      bypass_request <= 1'b1;
    end else begin
      if (loop_mode == LB_NET || loop_mode == LB_DUAL) begin
        net_tx_sel <= TX_LOOP;
      end else if (pat_on) begin
        net_tx_sel <= TX_PATTERN;
      end else if (customer_side.los) begin
        // [RULE_02] Provisioned keep-alive
        unique case (dlt_ka_t'(prov[PROV_KA_LSB +: 2]))
          KA_IDLE: net_tx_sel <= TX_IDLE;
          KA_AIS: net_tx_sel <= TX_AIS;
          default: net_tx_sel <= TX_OFF;
        endcase
      end else begin
        net_tx_sel <= TX_THRU;
      end
      if (loop_mode == LB_CUSTOMER_SIDE || loop_mode == LB_DUAL) begin
        customer_side_tx_sel <= TX_LOOP;
      end else if (pat_on) begin
        customer_side_tx_sel <= TX_PATTERN;
      end else if (network_side.los) begin
        // [RULE_01] Unframed all ones keep-alive
        customer_side_tx_sel <= TX_ALL_ONES;
      end else begin
        customer_side_tx_sel <= TX_THRU;
      end
      // [RULE_01] Network loss indicator
      network_loss_indicator.loss <= network_side.los;
      // [RULE_02] Customer loss indicator
      customer_loss_indicator.loss <= customer_side.los;
      // [RULE_03] Unframed when neither framing found
      network_loss_indicator.cbit <= network_side.cbit_found;
      network_loss_indicator.m13 <= network_side.m13_found;
      network_loss_indicator.unframed <=
        ~(network_side.cbit_found | network_side.m13_found);
      customer_loss_indicator.cbit <= customer_side.cbit_found;
      customer_loss_indicator.m13 <= customer_side.m13_found;
      customer_loss_indicator.unframed <=
        ~(customer_side.cbit_found | customer_side.m13_found);
      // [RULE_06] Bypass on failure or flash upgrade
      bypass_request <= card_fail | prov[PROV_FLASH];
    end
  end

  // Line defects
  assign next_fhist = {fhist[SEF_WINDOW-2:0], fbit_error};
  always_comb begin
    err_cnt = 5'h00;
    for (int i = 0; i < SEF_WINDOW; i++) begin
      err_cnt = err_cnt + 5'(next_fhist[i]);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fhist <= '0;
      sef_defect <= 1'b0;
      zero_run <= 2'h0;
      exz_flag <= 1'b0;
      prev_neg <= 1'b0;
      febe_cnt <= 16'h0000;
      bpv_cnt <= 16'h0000;
    end else begin
      // [RULE_20] Sixteen F-bit window
      if (fbit_valid) begin
        fhist <= next_fhist;
        if (err_cnt >= SEF_LIMIT) begin
          sef_defect <= 1'b1;
        end else if (in_frame) begin
          sef_defect <= 1'b0;
        end
      end
      // [RULE_22] Zero run beyond two
      if (line_bit_valid) begin
        zero_run <= line_bit ? 2'h0 :
          (zero_run == EXZ_LIMIT ? zero_run : zero_run + 2'h1);
        exz_flag <= ~line_bit & (zero_run == EXZ_LIMIT);
      end
      // [RULE_21] FEBE on C-bit only; count beats a clearing write
      if (febe_valid && network_side.cbit_found && febe_bits != 3'h7) begin
        febe_cnt <= (febe_cnt == 16'hFFFF) ? febe_cnt : febe_cnt + 16'h0001;
      end else if (wr && paddr == ADDR_FEBE_CNT) begin
        febe_cnt <= 16'h0000;
      end
      // [RULE_23] Same polarity, not substitution
      if (pulse_valid) begin
        prev_neg <= pulse_negative;
      end
      if (pulse_valid && !pulse_in_subst && pulse_negative == prev_neg) begin
        bpv_cnt <= (bpv_cnt == 16'hFFFF) ? bpv_cnt : bpv_cnt + 16'h0001;
      end else if (wr && paddr == ADDR_BPV_CNT) begin
        bpv_cnt <= 16'h0000;
      end
    end
  end

  // Craft transmitter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_shift <= 10'h3FF;
      tx_bits <= 4'h0;
      tx_baud <= 16'h0000;
      craft_txd <= 1'b1;
    end else if (tx_bits == 4'h0) begin
      craft_txd <= 1'b1;
      // [RULE_18] Start, eight data, one stop; writes while busy are lost
      if (wr && paddr == ADDR_UART_TX) begin
        tx_shift <= {1'b1, pwdata[7:0], 1'b0};
        tx_bits <= 4'(UART_DATA_BITS + 2);
        tx_baud <= 16'h0000;
      end
    end else begin
      craft_txd <= tx_shift[0];
      if (tx_baud == baud_div - 16'h0001) begin
        tx_baud <= 16'h0000;
        tx_shift <= {1'b1, tx_shift[9:1]};
        tx_bits <= tx_bits - 4'h1;
      end else begin
        tx_baud <= tx_baud + 16'h0001;
      end
    end
  end

  // Craft receiver; samples mid-bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_busy <= 1'b0;
      rx_bits <= 4'h0;
      rx_baud <= 16'h0000;
      rx_shift <= 8'h00;
      rx_data <= 8'h00;
      rx_valid <= 1'b0;
    end else begin
      if (rd && paddr == ADDR_UART_RX) begin
        rx_valid <= 1'b0;
      end
      if (!rx_busy) begin
        if (!craft_rxd) begin
          rx_busy <= 1'b1;
          rx_bits <= 4'h0;
          rx_baud <= {1'b0, baud_div[15:1]};
        end
      end else if (rx_baud == 16'h0000) begin
        rx_baud <= baud_div - 16'h0001;
        rx_bits <= rx_bits + 4'h1;
        if (rx_bits == 4'h0 && craft_rxd) begin
          rx_busy <= 1'b0;
        end else if (rx_bits == 4'(UART_DATA_BITS + 1)) begin
          // [RULE_18] Good stop bit; new byte wins over read clear
          rx_busy <= 1'b0;
          if (craft_rxd) begin
            rx_data <= rx_shift;
            rx_valid <= 1'b1;
          end
        end else if (rx_bits != 4'h0) begin
          rx_shift <= {craft_rxd, rx_shift[7:1]};
        end
      end else begin
        rx_baud <= rx_baud - 16'h0001;
      end
    end
  end

endmodule : dlt_ctrl

// ### dlt_far.sv
// Central office test set model: FEAC, inband codes, network framing
`timescale 1ns/1ps
module dlt_far (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [2:0] op,
  input wire logic [15:0] op_id,
  input wire logic net_los,
  output dlt_pkg::dlt_side_t network_side,
  output logic feac_loop_up,
  output logic feac_loop_down,
  output logic release_code,
  output logic arm_code_present,
  output logic id_valid,
  output logic [15:0] id_code
);
  import dlt_pkg::*;
  logic [7:0] cnt;
  logic [15:0] idr;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 8'h00;
      idr <= 16'h0000;
    end else if (op == 3'h4) begin
      // Arming outlasts five ticks from any phase
      cnt <= 8'h8C;
      idr <= op_id;
    end else if (cnt != 8'h00) begin
      cnt <= cnt - 8'h01;
    end
  end
  assign network_side = {net_los, !net_los, 1'b0};
  assign feac_loop_up = (op == 3'h1) && !net_los;
  assign feac_loop_down = (op == 3'h2);
  assign release_code = (op == 3'h3);
  assign arm_code_present = (cnt > 8'h02);
  assign id_valid = (cnt == 8'h02);
  assign id_code = id_valid ? idr : {cnt, ~cnt};
endmodule : dlt_far

// ### dlt_pkg.sv
// Shared constants, types and register map of the loopback test controller
package dlt_pkg;

  // Clock and time base
  localparam int CLK_HZ = 25_000_000;
  localparam int SEC_CYCLES = CLK_HZ;
  localparam int ARM_TIME_S = 5;
  localparam int ID_WINDOW_S = 20;
  localparam int TMO_20_MIN = 20;
  localparam int TMO_60_MIN = 60;
  localparam int TMO_120_MIN = 120;
  localparam int TMO_24_HOUR = 24;
  localparam logic [16:0] TMO_20_S = 17'(TMO_20_MIN * 60);
  localparam logic [16:0] TMO_60_S = 17'(TMO_60_MIN * 60);
  localparam logic [16:0] TMO_120_S = 17'(TMO_120_MIN * 60);
  localparam logic [16:0] TMO_24H_S = 17'(TMO_24_HOUR * 3600);

  // Craft port rates
  localparam int BAUD_MIN = 1200;
  localparam int BAUD_MAX = 19200;
  localparam logic [15:0] DIV_MIN = 16'(CLK_HZ / BAUD_MAX);
  localparam logic [15:0] DIV_MAX = 16'(CLK_HZ / BAUD_MIN);
  localparam logic [15:0] DIV_RESET = 16'(CLK_HZ / 9600);
  localparam int UART_DATA_BITS = 8;

  // Inband identifier codes
  localparam logic [15:0] ID_LOOPBACK = 16'hD3D3;
  localparam logic [15:0] ID_PRBS23 = 16'h2E23;
  localparam logic [15:0] ID_QRSS = 16'h2E20;
  localparam logic [15:0] ID_BLUE = 16'hD741;
  localparam logic [15:0] ID_IDLE = 16'hD742;
  localparam logic [15:0] ID_USER = 16'hD743;
  localparam logic [15:0] USER_PAT_RESET = 16'h00FF;

  // Defect thresholds
  localparam int SEF_WINDOW = 16;
  localparam logic [4:0] SEF_LIMIT = 5'h03;
  localparam logic [1:0] EXZ_LIMIT = 2'h2;

  // Register byte addresses
  localparam logic [7:0] ADDR_PROV = 8'h00;
  localparam logic [7:0] ADDR_CMD = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_USER_PAT = 8'h0C;
  localparam logic [7:0] ADDR_BAUD_DIV = 8'h10;
  localparam logic [7:0] ADDR_UART_TX = 8'h14;
  localparam logic [7:0] ADDR_UART_RX = 8'h18;
  localparam logic [7:0] ADDR_FEBE_CNT = 8'h1C;
  localparam logic [7:0] ADDR_BPV_CNT = 8'h20;

  // Provisioning field positions and reset value
  localparam int PROV_KA_LSB = 0;
  localparam int PROV_TMO_LSB = 2;
  localparam int PROV_INBAND = 5;
  localparam int PROV_FLASH = 6;
  localparam logic [6:0] PROV_RESET = 7'h2D;
  // Command field positions
  localparam int CMD_LOOP_LSB = 0;
  localparam int CMD_LOOP_GO = 2;
  localparam int CMD_PAT_LSB = 3;
  localparam int CMD_PAT_GO = 6;
  localparam int CMD_RELEASE = 7;

  typedef enum logic [1:0] {KA_IDLE, KA_AIS, KA_NONE} dlt_ka_t;
  typedef enum logic [2:0] {
    TMO_OFF, TMO_20, TMO_60, TMO_120, TMO_24H
  } dlt_tmo_t;
  typedef enum logic [1:0] {LB_NONE, LB_NET, LB_CUSTOMER_SIDE, LB_DUAL} dlt_loop_t;
  typedef enum logic [2:0] {
    PAT_PRBS23, PAT_QRSS, PAT_BLUE, PAT_IDLE, PAT_USER
  } dlt_pat_t;
  typedef enum logic [1:0] {FR_UNFR, FR_CBIT, FR_M13} dlt_frame_t;
  typedef enum logic [2:0] {
    TX_THRU, TX_ALL_ONES, TX_IDLE, TX_AIS, TX_OFF, TX_PATTERN, TX_LOOP
  } dlt_tx_t;

  // Receive status of one side, from the line framer
  typedef struct packed {
    logic los;
    logic cbit_found;
    logic m13_found;
  } dlt_side_t;

  // Indicators for one side
  typedef struct packed {
    logic loss;
    logic cbit;
    logic m13;
    logic unframed;
  } dlt_led_t;

endpackage : dlt_pkg

// ### dlt_props.sv
// Checker of indicators, defects and test modes
`timescale 1ns/1ps
module dlt_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire dlt_pkg::dlt_side_t network_side,
  input wire dlt_pkg::dlt_side_t customer_side,
  input wire logic card_fail,
  input wire logic line_bit_valid,
  input wire logic line_bit,
  input wire logic fbit_valid,
  input wire logic fbit_error,
  input wire logic exz_flag,
  input wire logic sef_defect,
  input wire logic bypass_request,
  input wire dlt_pkg::dlt_led_t network_loss_indicator,
  input wire dlt_pkg::dlt_led_t customer_loss_indicator,
  input wire dlt_pkg::dlt_tx_t net_tx_sel,
  input wire dlt_pkg::dlt_tx_t customer_side_tx_sel
);
  import dlt_pkg::*;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_net_loss: assert property (
    1 |=> network_loss_indicator.loss == $past(network_side.los))
    else $error("network loss light wrong");
  a_customer_side_loss: assert property (
    1 |=> customer_loss_indicator.loss == $past(customer_side.los))
    else $error("customer loss light wrong");
  a_net_unframed: assert property (
    1 |=> network_loss_indicator.unframed ==
    $past(!network_side.cbit_found && !network_side.m13_found))
    else $error("unframed light wrong");
  a_bypass_req: assert property (card_fail |=> bypass_request)
    else $error("bypass not requested");
  a_exz_run: assert property (
    (line_bit_valid && !line_bit)[*3] |=> exz_flag)
    else $error("zero run not flagged");
  a_exz_cause: assert property (
    $rose(exz_flag) |-> $past(line_bit_valid && !line_bit))
    else $error("zero flag without a zero");
  a_sef_cause: assert property (
    $rose(sef_defect) |-> $past(fbit_valid && fbit_error))
    else $error("frame defect without an error");
  a_no_mix: assert property (
    !(net_tx_sel == TX_PATTERN && customer_side_tx_sel == TX_LOOP) &&
    !(net_tx_sel == TX_LOOP && customer_side_tx_sel == TX_PATTERN))
    else $error("pattern and loop at once");
  c_loop: cover property (net_tx_sel == TX_LOOP);
  c_pat: cover property (customer_side_tx_sel == TX_PATTERN);
  c_sef: cover property (sef_defect);
endmodule : dlt_props
bind dlt_ctrl dlt_props dlt_props_i (.*);

// ### testbench.sv
// Self-checking bench of the loopback test controller
`timescale 1ns/1ps
module testbench;
  import dlt_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic pready, pslverr, err, craft_txd, bypass_request, sef_defect;
  logic [2:0] op = 3'h0, febe_bits = 3'h7;
  logic [15:0] op_id = 16'h0000, user_pattern, id_code;
  logic net_los = 0, feac_loop_up, feac_loop_down, arm_code_present;
  logic release_code, id_valid, loopback_select_button = 0, exz_flag;
  logic card_fail = 0, fbit_valid = 0, fbit_error = 0, in_frame = 1;
  logic febe_valid = 0, line_bit_valid = 0, line_bit = 1;
  logic pulse_valid = 0, pulse_negative = 0, pulse_in_subst = 0;
  dlt_side_t network_side, customer_side = 3'h0;
  dlt_led_t network_loss_indicator, customer_loss_indicator;
  dlt_tx_t net_tx_sel, customer_side_tx_sel;
  dlt_pat_t pattern_sel;
  dlt_frame_t pattern_framing;
  int num_errors = 0, n_tests = 0, cyc = 0;
  dlt_tx_t kas [3] = '{TX_IDLE, TX_AIS, TX_OFF};
  logic [15:0] ids [5] = '{ID_PRBS23, ID_QRSS, ID_BLUE, ID_IDLE, ID_USER};
  // Short second so timeouts fit the run
  dlt_ctrl #(.SEC_TICK(20)) dlt_ctrl_i (.*, .craft_rxd(craft_txd));
  dlt_far dlt_far_i (.*);
  initial forever #20 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 100000) begin
      num_errors++;
      wrap_up();
    end
  end
  task automatic wrap_up;
    if (num_errors == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %0t got %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask : tick
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  task automatic far(input logic [2:0] o, input logic [15:0] id);
    op <= o;
    op_id <= id;
    tick(1);
    op <= 3'h0;
    tick(150);
  endtask : far
  task automatic loop_is(input dlt_loop_t l);
    apb(0, ADDR_STATUS, '0);
    chk(rd[5:4], l);
  endtask : loop_is
  task automatic press;
    loopback_select_button <= 1;
    tick(1);
    loopback_select_button <= 0;
    tick(4);
  endtask : press
  initial begin
    tick(3);
    presetn <= 1;
    apb(0, ADDR_PROV, '0);
    chk(rd, PROV_RESET);
    apb(0, ADDR_BAUD_DIV, '0);
    chk(rd, DIV_RESET);
    chk(bypass_request, 0);
    chk(customer_loss_indicator.unframed, 1);
    apb(0, 8'h24, '0);
    chk(err, 1);
    apb(1, ADDR_BAUD_DIV, 32'h0000_0064);
    chk(err, 1);
    apb(1, ADDR_BAUD_DIV, DIV_MIN);
    apb(1, ADDR_UART_TX, 32'h0000_00A5);
    net_los <= 1;
    tick(3);
    chk(customer_side_tx_sel, TX_ALL_ONES);
    net_los <= 0;
    customer_side <= 3'h4;
    for (int k = 0; k < 3; k++) begin
      apb(1, ADDR_PROV, 32'h0000_002C + k);
      tick(3);
      chk(net_tx_sel, kas[k]);
    end
    customer_side <= 3'h2;
    far(3'h1, '0);
    loop_is(LB_NET);
    far(3'h2, '0);
    chk(net_tx_sel, TX_THRU);
    far(3'h4, ID_LOOPBACK);
    loop_is(LB_NET);
    far(3'h3, '0);
    loop_is(LB_NONE);
    apb(1, ADDR_USER_PAT, 32'h0000_1234);
    tick(1);
    chk(user_pattern, 16'h1234);
    for (int k = 0; k < 5; k++) begin
      far(3'h4, ids[k]);
      chk(pattern_sel, dlt_pat_t'(k));
      chk(net_tx_sel, TX_PATTERN);
      chk(customer_side_tx_sel, TX_PATTERN);
      chk(pattern_framing, FR_CBIT);
      far(3'h3, '0);
      chk(net_tx_sel, TX_THRU);
    end
    far(3'h4, 16'h1111);
    apb(0, ADDR_STATUS, '0);
    chk(rd[15:14], 2'h0);
    apb(1, ADDR_PROV, 32'h0000_0025);
    apb(1, ADDR_CMD, 32'h0000_0005);
    loop_is(LB_NET);
    tick(12000);
    far(3'h1, '0);
    tick(20000);
    loop_is(LB_NET);
    tick(6000);
    loop_is(LB_NONE);
    apb(0, ADDR_UART_RX, '0);
    chk(rd, 32'h0000_01A5);
    apb(1, ADDR_PROV, 32'h0000_0021);
    press();
    tick(24100);
    loop_is(LB_NET);
    press();
    loop_is(LB_NONE);
    card_fail <= 1;
    fbit_valid <= 1;
    fbit_error <= 1;
    line_bit_valid <= 1;
    line_bit <= 0;
    febe_valid <= 1;
    febe_bits <= 3'h3;
    pulse_valid <= 1;
    pulse_negative <= 1;
    tick(1);
    pulse_valid <= 0;
    apb(1, ADDR_BPV_CNT, '0);
    febe_valid <= 0;
    pulse_valid <= 1;
    pulse_negative <= 0;
    tick(2);
    pulse_in_subst <= 1;
    tick(1);
    {fbit_valid, line_bit_valid, pulse_valid} <= 3'h0;
    tick(2);
    chk(bypass_request, 1);
    chk(sef_defect, 1);
    apb(0, ADDR_BPV_CNT, '0);
    chk(rd, 32'h0000_0001);
    apb(0, ADDR_FEBE_CNT, '0);
    chk(rd, 32'h0000_0004);
    chk(exz_flag, 1);
    wrap_up();
  end
endmodule : testbench
